// >>> src/cdu_ctrl.sv
module cdu_ctrl #(
	parameter int N_OUT = 4,
	parameter int LOAD_WAIT_CYCLES = cdu_pkg::SEQ_LOAD_DELAY_CYC,
	parameter int REC_BYTE_CYCLES = cdu_pkg::REC_BYTE_CYC
) (
	input wire logic CLK, // System clock
	input wire logic RESET, // Synchronous reset
	input wire logic LOCKOUT_OK, // Supply above lockout, pin
	input wire logic SUPPLY_PRESENT, // Any input above 1.2 V, pin
	input wire logic HV_UV_FAULT, // High-voltage input below threshold, pin
	input wire logic REQ_VALID, // Host request offered
	output logic REQ_READY, // Request accepted
	input wire logic [cdu_pkg::REQ_KIND_W-1:0] REQ_KIND, // Request kind
	input wire logic [cdu_pkg::NV_AW-1:0] REQ_ADDR, // Byte address
	input wire logic [7:0] REQ_DATA, // Write data
	output logic ANS_ACK, // Request done pulse
	output logic ANS_NACK, // Request refused pulse
	input wire logic [cdu_pkg::CFG_IW-1:0] CFG_RD_ADDR, // Active latch select
	output logic [7:0] CFG_RD_DATA, // Active latch value
	output logic [N_OUT-1:0] PROG_OUT, // Output levels
	output logic PROG_OUT_OE, // Outputs driven
	output logic PROG_OUT_PULLDN, // Weak pull-down engaged
	input wire logic SEQ_EXIT, // Exit conditions met
	input wire logic [cdu_pkg::SEQ_SLOT_W-1:0] SEQ_NEXT_STATE, // Next state number
	output logic [63:0] STATE_WORD, // Active state word
	output logic STATE_VALID, // Word usable
	output logic [cdu_pkg::SEQ_SLOT_W-1:0] STATE_NUM, // Active state number
	output logic CFG_LOADED, // Power-up load complete
	output logic UPD_TRANSPARENT, // Transparent mode
	output logic UPD_STROBE, // Update bit readback
	output logic ERASE_EN, // Page erase allowed
	output logic REC_BUSY, // Fault record writing
	output logic REC_FULL // All record slots used
);
	import cdu_pkg::*;

	typedef struct packed {
		cdu_state_e st;
		logic [2:0] s1;
		logic [2:0] s2;
		logic hv_prev;
		logic loaded;
		logic reload;
		logic ph;
		logic transparent;
		logic erase_en;
		logic upd_strobe;
		logic [16:0] tmr;
		logic [NV_AW-1:0] idx;
		logic [NV_AW-1:0] base;
		logic [SEQ_SLOT_W-1:0] cur_state;
		logic [63:0] word;
		logic word_valid;
		logic [3:0] rec_ptr;
		logic rec_full;
		logic [7:0] csum;
		logic ack;
		logic nack;
		logic [7:0] rd_data;
		logic [CFG_BYTES-1:0][7:0] la;
		logic [CFG_BYTES-1:0][7:0] lb;
	} cdu_ctrl_s;

	cdu_ctrl_s r;
	cdu_ctrl_s next_r;
	logic q_valid;
	logic q_ready;
	logic [REQ_W-1:0] q_data;
	logic [REQ_KIND_W-1:0] q_kind;
	logic [NV_AW-1:0] q_addr;
	logic [7:0] q_byte;
	logic pop;
	logic [NV_AW-1:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_wd;
	logic [7:0] mem_rd;
	logic fault_edge;
	logic [7:0] rec_byte;

	// Requests queue up while the controller is busy
	cdu_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.reset(RESET),
		.in_valid(REQ_VALID),
		.in_ready(REQ_READY),
		.in_data({REQ_KIND, REQ_ADDR, REQ_DATA}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	cdu_nv_mem #(
		.AW(NV_AW),
		.DEPTH(NV_DEPTH)
	) u_nv (
		.clk(CLK),
		.addr(mem_addr),
		.we(mem_we),
		.wd(mem_wd),
		.rd(mem_rd)
	);

	assign {q_kind, q_addr, q_byte} = q_data;
	assign fault_edge = r.s2[2] & ~r.hv_prev & ~r.rec_full;
	// Before load every request is drained and refused; afterwards only RUN drains
	assign q_ready = ~r.loaded | ((r.st == ST_RUN) & ~fault_edge & ~SEQ_EXIT);
	assign pop = q_valid & q_ready;

	// Record layout: state number, six word bytes, checksum
	always_comb begin
		if (r.idx == '0) begin
			rec_byte = {2'b00, r.cur_state};
		end else if (r.idx == WORD_LAST) begin
			rec_byte = r.csum;
		end else begin
			rec_byte = r.word[{r.idx[2:0], 3'b000} +: 8];
		end
	end

	// Next-state logic of the whole controller
	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		next_r.nack = 1'b0;
		next_r.upd_strobe = 1'b0;
		next_r.s1 = {HV_UV_FAULT, SUPPLY_PRESENT, LOCKOUT_OK};
		next_r.s2 = r.s1;
		next_r.hv_prev = r.s2[2];
		next_r.rd_data = (CFG_RD_ADDR < 8'(CFG_BYTES)) ? r.lb[CFG_RD_ADDR] : 8'h00;
		mem_addr = r.base + r.idx;
		mem_we = 1'b0;
		mem_wd = 8'h00;
		// One pulse moves every first stage into its second stage
		if (r.upd_strobe) begin
			next_r.lb = r.la;
		end
		unique case (r.st)
			ST_OFF: begin
				if (r.s2[0]) begin
					next_r.st = ST_DL_A;
					next_r.idx = '0;
					next_r.base = '0;
					next_r.ph = 1'b0;
				end
			end
			ST_DL_A: begin
				// Two cycles a byte: address, then registered data
				next_r.ph = ~r.ph;
				if (r.ph) begin
					next_r.la[r.idx[CFG_IW-1:0]] = mem_rd;
					if (r.idx == CFG_LAST) begin
						next_r.st = ST_DL_B;
					end else begin
						next_r.idx = r.idx + 1'b1;
					end
				end
			end
			ST_DL_B: begin
				next_r.lb = r.la;
				next_r.loaded = 1'b1;
				next_r.reload = 1'b0;
				if (r.reload) begin
					next_r.st = ST_RUN;
				end else begin
					next_r.st = ST_WAIT_SEQ;
					next_r.tmr = 17'(LOAD_WAIT_CYCLES - 1);
				end
			end
			ST_WAIT_SEQ: begin
				next_r.tmr = r.tmr - 1'b1;
				if (r.tmr == '0) begin
					next_r.st = ST_FETCH;
					next_r.base = SEQ_BASE;
					next_r.idx = '0;
					next_r.ph = 1'b0;
					next_r.cur_state = '0;
					next_r.tmr = 17'(FETCH_CYC - 1);
				end
			end
			ST_FETCH: begin
				// Fetch window is timed, byte reads finish well inside it
				next_r.tmr = r.tmr - 1'b1;
				if (r.idx <= WORD_LAST) begin
					next_r.ph = ~r.ph;
					if (r.ph) begin
						next_r.word[{r.idx[2:0], 3'b000} +: 8] = mem_rd;
						next_r.idx = r.idx + 1'b1;
					end
				end
				if (r.tmr == '0) begin
					next_r.st = ST_RUN;
					next_r.word_valid = 1'b1;
				end
			end
			ST_RUN: begin
				if (fault_edge) begin
					next_r.st = ST_REC;
					next_r.idx = '0;
					next_r.csum = 8'h00;
					next_r.base = REC_BASE + {r.rec_ptr, 3'b000};
					next_r.tmr = 17'(REC_BYTE_CYCLES - 1);
				end else if (SEQ_EXIT) begin
					// Word is always reread from storage, never cached
					next_r.st = ST_FETCH;
					next_r.word_valid = 1'b0;
					next_r.cur_state = SEQ_NEXT_STATE;
					next_r.base = SEQ_BASE + {SEQ_NEXT_STATE, 3'b000};
					next_r.idx = '0;
					next_r.ph = 1'b0;
					next_r.tmr = 17'(FETCH_CYC - 1);
				end
			end
			ST_ERASE: begin
				mem_we = 1'b1;
				mem_wd = ERASE_BYTE;
				if (r.idx == PAGE_LAST) begin
					next_r.st = ST_RUN;
				end else begin
					next_r.idx = r.idx + 1'b1;
				end
			end
			ST_REC: begin
				// One byte written per slot, slot held for its full write time
				next_r.tmr = r.tmr - 1'b1;
				if (r.tmr == 17'(REC_BYTE_CYCLES - 1)) begin
					mem_we = 1'b1;
					mem_wd = rec_byte;
					next_r.csum = r.csum + rec_byte;
				end
				if (r.tmr == '0) begin
					if (r.idx == WORD_LAST) begin
						next_r.st = ST_RUN;
						next_r.rec_ptr = r.rec_ptr + 1'b1;
						next_r.rec_full = (r.rec_ptr == 4'hf);
					end else begin
						next_r.idx = r.idx + 1'b1;
						next_r.tmr = 17'(REC_BYTE_CYCLES - 1);
					end
				end
			end
		endcase
		// Request handling; the queue drains only when it may
		if (pop && !r.loaded) begin
			next_r.nack = 1'b1;
		end else if (pop) begin
			next_r.ack = 1'b1;
			unique case (cdu_req_e'(q_kind))
				REQ_CFG_WR: begin
					if (q_addr <= CFG_LAST) begin
						next_r.la[q_addr[CFG_IW-1:0]] = q_byte;
						if (r.transparent) begin
							next_r.lb[q_addr[CFG_IW-1:0]] = q_byte;
						end
					end else begin
						next_r.ack = 1'b0;
						next_r.nack = 1'b1;
					end
				end
				REQ_NV_WR: begin
					mem_addr = q_addr;
					mem_we = 1'b1;
					mem_wd = q_byte;
				end
				REQ_ERASE: begin
					if (r.erase_en) begin
						next_r.st = ST_ERASE;
						next_r.base = {q_addr[NV_AW-1:PAGE_AW], 5'h00};
						next_r.idx = '0;
					end
				end
				REQ_RELOAD: begin
					next_r.st = ST_DL_A;
					next_r.reload = 1'b1;
					next_r.base = '0;
					next_r.idx = '0;
					next_r.ph = 1'b0;
				end
				REQ_CTRL: begin
					next_r.transparent = q_byte[CTL_TRANSPARENT_BIT];
					next_r.erase_en = q_byte[CTL_ERASE_EN_BIT];
					next_r.upd_strobe = q_byte[CTL_UPDATE_BIT];
				end
				default: begin
					next_r.ack = 1'b0;
					next_r.nack = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Outputs held inactive until the configuration is in place
	assign PROG_OUT = r.loaded ? r.lb[0][N_OUT-1:0] : '0;
	assign PROG_OUT_OE = r.loaded;
	assign PROG_OUT_PULLDN = r.s2[1] & ~r.loaded;
	assign ANS_ACK = r.ack;
	assign ANS_NACK = r.nack;
	assign CFG_RD_DATA = r.rd_data;
	assign STATE_WORD = r.word;
	assign STATE_VALID = r.word_valid;
	assign STATE_NUM = r.cur_state;
	assign CFG_LOADED = r.loaded;
	assign UPD_TRANSPARENT = r.transparent;
	assign UPD_STROBE = r.upd_strobe;
	assign ERASE_EN = r.erase_en;
	assign REC_BUSY = (r.st == ST_REC);
	assign REC_FULL = r.rec_full;

	// Cycles spent in the present state, for timing checks
	logic [19:0] dwell;
	always_ff @(posedge CLK) begin
		if (RESET || (next_r.st != r.st)) begin
			dwell <= '0;
		end else begin
			dwell <= dwell + 1'b1;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence s_load_done;
		(r.st == ST_DL_B) && !r.reload;
	endsequence
	sequence s_cfg_wr(logic t);
		pop && r.loaded && (q_kind == REQ_CFG_WR) && (q_addr <= CFG_LAST) && (r.transparent == t);
	endsequence

	chk_ack_after_load: assert property (ANS_ACK |-> r.loaded && !ANS_NACK)
		else $error("ack before load");
	chk_outputs_inactive: assert property (!r.loaded |-> !PROG_OUT_OE && (PROG_OUT == '0))
		else $error("outputs active before load");
	chk_dl_waits_undervoltage_lockout: assert property ((r.st == ST_OFF) && !r.s2[0] |=> (r.st == ST_OFF))
		else $error("download before lockout release");
	chk_b_hold_dl: assert property ((r.st == ST_DL_A) |=> (r.lb == $past(r.lb)))
		else $error("second stage moved during download");
	chk_b_copy_all: assert property (s_load_done |=> (r.lb == $past(r.la)) && r.loaded)
		else $error("second stage copy incomplete");
	chk_seq_delay: assert property ((r.st == ST_WAIT_SEQ) && (next_r.st != ST_WAIT_SEQ)
		|-> (dwell == 20'(LOAD_WAIT_CYCLES - 1)) ##1 (r.st == ST_FETCH))
		else $error("state fetch delay wrong");
	chk_transparent_wr: assert property (s_cfg_wr(1'b1)
		|=> r.lb[$past(q_addr[CFG_IW-1:0])] == $past(q_byte))
		else $error("transparent write missed second stage");
	chk_staged_wr: assert property (s_cfg_wr(1'b0) && !r.upd_strobe |=> (r.lb == $past(r.lb)))
		else $error("staged write changed second stage");
	chk_update_copy: assert property (r.upd_strobe && !pop |=> (r.lb == $past(r.la)))
		else $error("update pulse did not copy");
	chk_update_clears: assert property (r.upd_strobe |=> !r.upd_strobe)
		else $error("update bit stuck");
	chk_nv_wr_keeps: assert property (pop && r.loaded && (q_kind == REQ_NV_WR) && !r.upd_strobe
		|=> (r.la == $past(r.la)) && (r.lb == $past(r.lb)))
		else $error("nonvolatile write touched latches");
	chk_reload_path: assert property ((r.st == ST_DL_B) && r.reload
		|=> (r.lb == $past(r.la)) && (r.st == ST_RUN))
		else $error("reload did not restore");
	chk_erase_gate: assert property (pop && r.loaded && (q_kind == REQ_ERASE) && !r.erase_en
		|=> (r.st == ST_RUN) && !(mem_we && !(pop && (q_kind == REQ_NV_WR))))
		else $error("erase not ignored");
	chk_fault_entry: assert property ((r.st == ST_RUN) && fault_edge |=> (r.st == ST_REC))
		else $error("fault did not start record");
	chk_rec_time: assert property ((r.st == ST_REC) && (next_r.st != ST_REC)
		|-> dwell == 20'(REC_BYTES * REC_BYTE_CYCLES - 1))
		else $error("record write time wrong");
	chk_fetch_time: assert property ((r.st == ST_FETCH) && (next_r.st != ST_FETCH)
		|-> (dwell == 20'(FETCH_CYC - 1)) && (r.idx == WORD_LAST + 1'b1))
		else $error("state fetch time wrong");
endmodule : cdu_ctrl

// >>> pkg/cdu_pkg.sv
package cdu_pkg;
	// Clock and time figures, each count derived from its time
	localparam int CLK_PERIOD_NS = 20;
	localparam int SEQ_LOAD_DELAY_NS = 500000;
	localparam int SEQ_LOAD_DELAY_CYC = (SEQ_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REC_WRITE_NS = 2000000;
	localparam int REC_BYTES = 8;
	localparam int REC_BYTE_CYC = (REC_WRITE_NS / REC_BYTES + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FETCH_NS = 10000;
	localparam int FETCH_CYC = (FETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Nonvolatile map: config cell low, state-definition cell high
	localparam int NV_AW = 10;
	localparam int NV_DEPTH = 1024;
	localparam logic [NV_AW-1:0] SEQ_BASE = 10'h200;
	localparam logic [NV_AW-1:0] REC_BASE = 10'h180;
	localparam int PAGE_AW = 5;
	localparam logic [NV_AW-1:0] PAGE_LAST = 10'h01f;
	localparam logic [7:0] ERASE_BYTE = 8'hff;
	localparam int SEQ_STATES = 63;
	localparam int SEQ_SLOT_W = 6;
	localparam logic [NV_AW-1:0] WORD_LAST = 10'h007;

	// Volatile configuration latches
	localparam int CFG_BYTES = 160;
	localparam int CFG_IW = 8;
	localparam logic [NV_AW-1:0] CFG_LAST = 10'h09f;

	// Update-control bit positions
	localparam int CTL_TRANSPARENT_BIT = 0;
	localparam int CTL_UPDATE_BIT = 1;
	localparam int CTL_ERASE_EN_BIT = 2;

	// Request stream
	localparam int REQ_KIND_W = 3;
	localparam int REQ_W = REQ_KIND_W + NV_AW + 8;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		REQ_CFG_WR = 3'h0,
		REQ_NV_WR = 3'h1,
		REQ_ERASE = 3'h2,
		REQ_RELOAD = 3'h3,
		REQ_CTRL = 3'h4
	} cdu_req_e;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_DL_A = 3'h1,
		ST_DL_B = 3'h2,
		ST_WAIT_SEQ = 3'h3,
		ST_FETCH = 3'h4,
		ST_RUN = 3'h5,
		ST_ERASE = 3'h6,
		ST_REC = 3'h7
	} cdu_state_e;
endpackage : cdu_pkg

// >>> src/cdu_fifo.sv
module cdu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous reset
	input wire logic in_valid, // Write request
	output logic in_ready, // Space available
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Data available
	input wire logic out_ready, // Consumer takes word
	output logic [WIDTH-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] count;
	} cdu_fifo_s;

	cdu_fifo_s r;
	cdu_fifo_s next_r;
	logic push;
	logic pop;

	// Handshakes straight from the occupancy count
	assign in_ready = (r.count != (AW + 1)'(DEPTH));
	assign out_valid = (r.count != '0);
	assign out_data = r.mem[r.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointer wrap relies on DEPTH being a power of two
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wp] = in_data;
			next_r.wp = r.wp + 1'b1;
		end
		if (pop) begin
			next_r.rp = r.rp + 1'b1;
		end
		if (push && !pop) begin
			next_r.count = r.count + 1'b1;
		end else if (pop && !push) begin
			next_r.count = r.count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : cdu_fifo

// >>> src/cdu_nv_mem.sv
module cdu_nv_mem #(
	parameter int AW = 10,
	parameter int DEPTH = 1024
) (
	input wire logic clk, // System clock
	input wire logic [AW-1:0] addr, // Byte address
	input wire logic we, // Write strobe
	input wire logic [7:0] wd, // Write data
	output logic [7:0] rd // Read data, one cycle late
);
	// Blank cells read as all ones, so a fresh part loads a defined value
	logic [7:0] mem [DEPTH] = '{default: '1};

	// Single port, registered read; contents survive reset
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wd;
		end
		rd <= mem[addr];
	end
endmodule : cdu_nv_mem

// >>> test/cdu_host.sv
module cdu_host (
	input wire logic CLK, // System clock
	input wire logic REQ_READY, // FIFO has room
	input wire logic ANS_ACK, // Done pulse
	input wire logic ANS_NACK, // Refused pulse
	output logic REQ_VALID, // Request offered
	output logic [cdu_pkg::REQ_KIND_W-1:0] REQ_KIND, // Request kind
	output logic [cdu_pkg::NV_AW-1:0] REQ_ADDR, // Byte address
	output logic [7:0] REQ_DATA // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	import cdu_pkg::*;
	int n_ack = 0;
	int n_nack = 0;

	// Idle bus at time zero
	initial begin
		REQ_VALID = 1'b0;
		REQ_KIND = '0;
		REQ_ADDR = '0;
		REQ_DATA = '0;
	end

	// Answers counted at the edge where the pulse stands
	always @(posedge CLK) begin
		if (ANS_ACK === 1'b1) n_ack++;
		if (ANS_NACK === 1'b1) n_nack++;
	end

	// Offer one request, held until the edge that takes it
	task automatic push(input logic [2:0] kind, input logic [9:0] addr, input logic [7:0] data);
		@(posedge CLK);
		REQ_VALID <= 1'b1;
		REQ_KIND <= kind;
		REQ_ADDR <= addr;
		REQ_DATA <= data;
		do @(posedge CLK); while (REQ_READY !== 1'b1);
		REQ_VALID <= 1'b0;
		// Released address and data lines must not keep the last value
		REQ_ADDR <= ~addr;
		REQ_DATA <= ~data;
	endtask : push

	// One request and its answer: 1 done, 0 refused, x none
	task automatic send(input logic [2:0] kind, input logic [9:0] addr, input logic [7:0] data,
		output logic ack);
		int a0;
		int n0;
		a0 = n_ack;
		n0 = n_nack;
		push(kind, addr, data);
		for (int i = 0; i < 2000 && n_ack == a0 && n_nack == n0; i++) begin
			@(posedge CLK);
			#1;
		end
		ack = (n_ack != a0) ? 1'b1 : (n_nack != n0) ? 1'b0 : 1'bx;
	endtask : send
endmodule : cdu_host

// >>> test/config_download_update_ctrl_tb.sv
module config_download_update_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cdu_pkg::*;
	// Short counts keep the run brief
	localparam int LW = 20;
	localparam int RB = 4;
	logic CLK, RESET, LOCKOUT_OK, SUPPLY_PRESENT, HV_UV_FAULT, SEQ_EXIT, ack;
	logic REQ_VALID, REQ_READY, ANS_ACK, ANS_NACK, PROG_OUT_OE, PROG_OUT_PULLDN;
	logic STATE_VALID, CFG_LOADED, UPD_TRANSPARENT, UPD_STROBE, ERASE_EN, REC_BUSY, REC_FULL;
	logic [REQ_KIND_W-1:0] REQ_KIND;
	logic [NV_AW-1:0] REQ_ADDR;
	logic [7:0] REQ_DATA, CFG_RD_DATA;
	logic [CFG_IW-1:0] CFG_RD_ADDR;
	logic [3:0] PROG_OUT;
	logic [SEQ_SLOT_W-1:0] SEQ_NEXT_STATE, STATE_NUM;
	logic [63:0] STATE_WORD, w;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_strobe = 0;
	int n;

	cdu_ctrl #(.N_OUT(4), .LOAD_WAIT_CYCLES(LW), .REC_BYTE_CYCLES(RB)) i_dut (.CLK, .RESET,
		.LOCKOUT_OK, .SUPPLY_PRESENT, .HV_UV_FAULT, .REQ_VALID, .REQ_READY, .REQ_KIND, .REQ_ADDR,
		.REQ_DATA, .ANS_ACK, .ANS_NACK, .CFG_RD_ADDR, .CFG_RD_DATA, .PROG_OUT, .PROG_OUT_OE,
		.PROG_OUT_PULLDN, .SEQ_EXIT, .SEQ_NEXT_STATE, .STATE_WORD, .STATE_VALID, .STATE_NUM,
		.CFG_LOADED, .UPD_TRANSPARENT, .UPD_STROBE, .ERASE_EN, .REC_BUSY, .REC_FULL);
	cdu_host i_host (.CLK, .REQ_READY, .ANS_ACK, .ANS_NACK, .REQ_VALID, .REQ_KIND, .REQ_ADDR,
		.REQ_DATA);

	// Clock, 20 ns period
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	// Update pulses counted so a single pulse can be told from a level
	always @(posedge CLK) if (UPD_STROBE === 1'b1) n_strobe++;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// Settled sampling point just after an edge
	task automatic cyc(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask : cyc

	task automatic req(input logic [2:0] kind, input logic [9:0] a, input logic [7:0] d,
		input logic exp);
		i_host.send(kind, a, d, ack);
		chk(ack, exp);
	endtask : req

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK);
		CFG_RD_ADDR <= a;
		cyc(2);
		chk(CFG_RD_DATA, exp);
	endtask : rd

	// Reload is answered when taken; the copy runs two cycles a byte after that
	task automatic reload_wait();
		req(REQ_RELOAD, 10'h000, 8'h00, 1'b1);
		cyc(2 * CFG_BYTES + 4);
	endtask : reload_wait

	// Powered but below lockout: outputs held, host refused
	task automatic t_early();
		@(posedge CLK);
		SUPPLY_PRESENT <= 1'b1;
		cyc(5);
		chk({PROG_OUT_PULLDN, PROG_OUT_OE, PROG_OUT}, 6'h20);
		req(REQ_CFG_WR, 10'h000, 8'h11, 1'b0);
		cyc(50);
		chk(CFG_LOADED, 1'b0);
	endtask : t_early

	// Lockout released: download, copy, first fetch
	task automatic t_powerup();
		@(posedge CLK);
		LOCKOUT_OK <= 1'b1;
		for (n = 0; n < 2000 && CFG_LOADED !== 1'b1; n++) cyc(1);
		chk(n >= 320 && n <= 330, 1'b1);
		cyc(1);
		chk({PROG_OUT_OE, PROG_OUT_PULLDN}, 2'h2);
		for (n = 0; n < 2000 && STATE_VALID !== 1'b1; n++) cyc(1);
		chk(n >= LW + FETCH_CYC - 5 && n <= LW + FETCH_CYC + 5, 1'b1);
	endtask : t_powerup

	// Three update modes and the update strobe
	task automatic t_modes();
		req(REQ_CTRL, 10'h000, 8'h01, 1'b1);
		req(REQ_CFG_WR, 10'h000, 8'h0a, 1'b1);
		rd(8'h00, 8'h0a);
		req(REQ_NV_WR, 10'h000, 8'h05, 1'b1);
		rd(8'h00, 8'h0a);
		reload_wait();
		rd(8'h00, 8'h05);
		chk(PROG_OUT, 4'h5);
		req(REQ_CTRL, 10'h000, 8'h00, 1'b1);
		req(REQ_CFG_WR, 10'h000, 8'h03, 1'b1);
		rd(8'h00, 8'h05);
		n = n_strobe;
		req(REQ_CTRL, 10'h000, 8'h02, 1'b1);
		rd(8'h00, 8'h03);
		chk({UPD_STROBE, UPD_TRANSPARENT}, 2'h0);
		req(REQ_CFG_WR, 10'h000, 8'h07, 1'b1);
		req(REQ_CTRL, 10'h000, 8'h02, 1'b1);
		rd(8'h00, 8'h07);
		chk(n_strobe - n, 2);
		req(REQ_CFG_WR, 10'h0a0, 8'h01, 1'b0);
		req(3'h5, 10'h000, 8'h01, 1'b0);
	endtask : t_modes

	// Page erase gated by the enable bit
	task automatic t_erase();
		req(REQ_NV_WR, 10'h021, 8'h12, 1'b1);
		req(REQ_ERASE, 10'h020, 8'h00, 1'b1);
		reload_wait();
		rd(8'h21, 8'h12);
		req(REQ_CTRL, 10'h000, 8'h04, 1'b1);
		chk(ERASE_EN, 1'b1);
		req(REQ_ERASE, 10'h03f, 8'h00, 1'b1);
		reload_wait();
		rd(8'h21, ERASE_BYTE);
		req(REQ_CTRL, 10'h000, 8'h00, 1'b1);
	endtask : t_erase

	task automatic exit_to(input logic [5:0] s);
		@(posedge CLK);
		SEQ_EXIT <= 1'b1;
		SEQ_NEXT_STATE <= s;
		@(posedge CLK);
		SEQ_EXIT <= 1'b0;
		#1;
	endtask : exit_to

	// State fetch, stall-filled FIFO, then a rewritten stored word
	task automatic t_fetch();
		for (int k = 0; k < 8; k++) begin
			req(REQ_NV_WR, SEQ_BASE + 10'h008 + 10'(k), 8'h10 + 8'(k), 1'b1);
			w[8*k+:8] = 8'h10 + 8'(k);
		end
		exit_to(6'h01);
		n = i_host.n_ack;
		for (int k = 0; k < FIFO_DEPTH; k++) i_host.push(REQ_CFG_WR, 10'h010 + 10'(k), 8'(k));
		cyc(1);
		chk(REQ_READY, 1'b0);
		for (int k = 0; k < 2000 && STATE_VALID !== 1'b1; k++) cyc(1);
		chk(STATE_NUM, 6'h01);
		chk(STATE_WORD, w);
		for (int k = 0; k < 200 && i_host.n_ack != n + FIFO_DEPTH; k++) cyc(1);
		chk(i_host.n_ack - n, FIFO_DEPTH);
		// Staged mode is active, so the queued writes need an update pulse
		req(REQ_CTRL, 10'h000, 8'h02, 1'b1);
		rd(8'h17, 8'h07);
		req(REQ_NV_WR, SEQ_BASE + 10'h008, 8'h5a, 1'b1);
		w[7:0] = 8'h5a;
		exit_to(6'h01);
		for (n = 0; n < 2000 && STATE_VALID !== 1'b1; n++) cyc(1);
		chk(n, FETCH_CYC);
		chk(STATE_WORD, w);
	endtask : t_fetch

	// Undervoltage edge starts an eight-byte record
	task automatic t_fault();
		@(posedge CLK);
		HV_UV_FAULT <= 1'b1;
		for (n = 0; n < 20 && REC_BUSY !== 1'b1; n++) cyc(1);
		chk(n < 20, 1'b1);
		for (n = 0; n < 1000 && REC_BUSY === 1'b1; n++) cyc(1);
		chk(n, REC_BYTES * RB);
		@(posedge CLK);
		HV_UV_FAULT <= 1'b0;
		cyc(5);
		chk(REC_FULL, 1'b0);
	endtask : t_fault

	// Main sequence
	initial begin
		RESET = 1'b1;
		LOCKOUT_OK = 1'b0;
		SUPPLY_PRESENT = 1'b0;
		HV_UV_FAULT = 1'b0;
		SEQ_EXIT = 1'b0;
		SEQ_NEXT_STATE = '0;
		CFG_RD_ADDR = '0;
		repeat (12) @(posedge CLK);
		RESET <= 1'b0;
		cyc(1);
		chk({CFG_LOADED, PROG_OUT_OE, REQ_READY}, 3'h1);
		t_early();
		t_powerup();
		t_modes();
		t_erase();
		t_fetch();
		t_fault();
		wrap_up();
	end

	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (30000) @(posedge CLK);
		n_mismatch++;
		wrap_up();
	end
endmodule : config_download_update_ctrl_tb
